// ---- dv/mrps_chk.sv ----
// Port-level assertion checker for the result and shifter block
`timescale 1ns/100ps
module mrps_chk
   import mrps_pkg::*;
#(
   parameter int MAX_SHIFT = MAX_SHF
) (
   input wire logic        clk,                 // Clock
   input wire logic        rstn,                // Reset, low
   input wire logic [7:0]  sfr_addr,            // Address
   input wire logic        sfr_wr,              // Write
   input wire logic [7:0]  sfr_wdata,           // Write data
   input wire logic        sfr_rd,              // Read
   input wire logic [7:0]  sfr_rdata,           // Read data
   input wire logic        sfr_rd_hit,          // Read claimed
   input wire logic [15:0] operand_a,           // Operand A
   input wire logic [15:0] operand_b,           // Operand B
   input wire logic [15:0] operand_bb,          // Alternate B
   input wire logic [31:0] adder_sum,           // Adder output
   input wire logic        overflow32_flag,     // Overflow
   input wire logic [31:0] product,             // Product
   input wire logic [31:0] prior_result,        // Prior
   input wire logic [31:0] accum_result,        // Result
   input wire logic [31:0] overflow32_capture,  // Capture
   input wire logic [1:0]  adder_source_select, // Adder source
   input wire logic        ovf_hold_mode        // Hold mode
);
   logic [7:0] shc_r;
   logic [7:0] ctl_r;
   logic [1:0] up_r;
   function automatic logic [31:0] shf(logic [31:0] x, logic [7:0] c);
      logic [5:0] m;
      m = c[5] ? -c[5:0] : c[5:0];
      if (m > 6'(MAX_SHIFT)) m = 6'(MAX_SHIFT);
      if (!c[5]) return (c[7] && c[6]) ? {x[31], x[30:0] << m} : x << m;
      return c[7] ? 32'($signed(x) >>> m) : x >> m;
   endfunction : shf
   // Mirrors of the two control registers, seen from the write port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shc_r <= 8'h00;
         ctl_r <= 8'h00;
         up_r  <= 2'h0;
      end else begin
         if (up_r != 2'h3) up_r <= up_r + 2'h1;
         if (sfr_wr && sfr_addr == ADDR_SHIFTER_CTL) shc_r <= sfr_wdata;
         if (sfr_wr && sfr_addr == ADDR_MAC_CTRL1) ctl_r <= sfr_wdata;
      end
   end
   wire ld = sfr_wr && ((sfr_addr == ADDR_OPA_LOW && !ctl_r[6]) ||
             (sfr_addr == ADDR_MAC_CTRL1 && sfr_wdata[7:6] == 2'h3));
   wire rres = sfr_rd && sfr_addr[7:2] == 6'h3D;
   wire rpri = sfr_rd && sfr_addr[7:2] == 6'h3F;
   wire mapd = rres || rpri || sfr_addr == ADDR_MAC_CTRL1 ||
               sfr_addr == ADDR_SHIFTER_CTL;
   wire [15:0] opb = ctl_r[1] ? (ctl_r[0] ? operand_bb : prior_result[15:0])
                              : (ctl_r[0] ? operand_a : operand_b);
   wire signed [31:0] pm = $signed(operand_a) * $signed(opb);
   sequence s_byte(logic [31:0] w);
      sfr_rd_hit && sfr_rdata == 8'(w >> (8 * $past(sfr_addr[1:0])));
   endsequence
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   a_result_shift: assert property (up_r[1] |->
      accum_result == shf($past(adder_sum), $past(shc_r)))
      else $error("shifted result wrong");
   a_prior_load: assert property (ld |=>
      prior_result == $past(accum_result)) else $error("prior not loaded");
   a_prior_hold: assert property (!ld |=> $stable(prior_result))
      else $error("prior changed");
   a_read_live: assert property (rres && !ctl_r[4] |=>
      s_byte($past(accum_result))) else $error("result byte wrong");
   a_read_ovrd: assert property (rres && ctl_r[4] |=>
      s_byte($past(overflow32_capture))) else $error("override byte wrong");
   a_read_prior: assert property (rpri |=>
      s_byte($past(prior_result))) else $error("prior byte wrong");
   a_read_unmapped: assert property (sfr_rd && !mapd |=>
      !sfr_rd_hit && sfr_rdata == UNMAPPED_RD) else $error("stray read");
   a_ovf_capture: assert property ($rose(overflow32_flag) |=>
      overflow32_capture == accum_result) else $error("capture wrong");
   a_product_sel: assert property (up_r[1] |->
      product == $past(pm)) else $error("product wrong");
endmodule : mrps_chk

bind mrps_core mrps_chk #(.MAX_SHIFT(MAX_SHIFT)) u_chk (.*);

// ---- dv/mrps_cpu.sv ----
// Processor core model on the byte-wide register port
`timescale 1ns/100ps
module mrps_cpu (
   input  wire logic       clk,        // Clock
   output logic      [7:0] sfr_addr,   // Address
   output logic            sfr_wr,     // Write strobe
   output logic      [7:0] sfr_wdata,  // Write data
   output logic            sfr_rd,     // Read strobe
   input  wire logic [7:0] sfr_rdata,  // Read data
   input  wire logic       sfr_rd_hit  // Read claimed
);
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   // Released lines flip so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr} = {~a, ~v, 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v,
                     output logic h);
      @(negedge clk);
      {sfr_addr, sfr_rd} = {a, 1'b1};
      @(negedge clk);
      {v, h} = {sfr_rdata, sfr_rd_hit};
      {sfr_addr, sfr_rd} = {~a, 1'b0};
   endtask : rd
endmodule : mrps_cpu

// ---- dv/testbench.sv ----
// Self-checking bench for the result and shifter block
`timescale 1ns/100ps
module testbench;
   import mrps_pkg::*;
   logic clk, rstn, sfr_wr, sfr_rd, sfr_rd_hit, overflow32_flag, h;
   logic ovf_hold_mode;
   logic [1:0] adder_source_select;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, c, d;
   logic [15:0] operand_a, operand_b, operand_bb, sel_b;
   logic [31:0] adder_sum, product, prior_result, accum_result;
   logic [31:0] overflow32_capture, ea, eb, w;
   logic [7:0] cor [8] = '{8'h10, 8'h30, 8'hBF, 8'hD0, 8'hC3, 8'h83,
                           8'h20, 8'h50};
   int bad_count, check_count, cyc, seed, i;
   mrps_core DUT (.*);
   mrps_cpu cpu (.*);
   function automatic logic [31:0] exp_shift(logic [31:0] x, logic [7:0] k);
      int n;
      n = $signed(k[5:0]);
      n = (n > 16) ? 16 : (n < -16) ? -16 : n;
      if (n >= 0) return (k[7] && k[6]) ? {x[31], 31'(x << n)} : x << n;
      return k[7] ? 32'($signed(x) >>> -n) : x >> -n;
   endfunction : exp_shift
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rd_word(input logic [7:0] base, input logic [31:0] e);
      for (int k = 0; k < 4; k++) begin
         cpu.rd(base + 8'(k), w[8*k +: 8], h);
         chk(32'(h), 32'h1);
      end
      chk(w, e);
   endtask : rd_word
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("Error %0t: run timed out", $time);
         give_verdict();
      end
   end
   initial begin
      seed = 32'h467b;
      {rstn, overflow32_flag, adder_sum} = '0;
      {operand_a, operand_b, operand_bb} = '0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      cpu.rd(ADDR_SHIFTER_CTL, d, h);
      chk(32'(d), 32'(SHC_RST));
      cpu.rd(8'hE0, d, h);
      chk(32'({h, d}), 32'(UNMAPPED_RD));
      rd_word(ADDR_RESULT0, WORD_RST);
      // Corner shift settings first, random ones after
      for (i = 0; i < 48; i++) begin
         c = (i < 8) ? cor[i] : 8'($random(seed));
         cpu.wr(ADDR_SHIFTER_CTL, c);
         adder_sum = $random(seed);
         adder_sum[31] = i[0];
         ea = exp_shift(adder_sum, c);
         @(negedge clk);
         chk(accum_result, ea);
         if (i % 6 == 0) rd_word(ADDR_RESULT0, ea);
      end
      cpu.rd(ADDR_SHIFTER_CTL, d, h);
      chk(32'(d), 32'(c));
      cpu.wr(ADDR_SHIFTER_CTL, 8'h00);
      cpu.wr(ADDR_MAC_CTRL1, 8'h00);
      ea = adder_sum;
      cpu.wr(ADDR_OPA_LOW, 8'h5A);
      rd_word(ADDR_PRIOR0, ea);
      adder_sum = ~adder_sum;
      cpu.wr(ADDR_MAC_CTRL1, 8'h40);
      cpu.wr(ADDR_OPA_LOW, 8'hA5);
      rd_word(ADDR_PRIOR0, ea);
      cpu.wr(ADDR_MAC_CTRL1, 8'hC0);
      rd_word(ADDR_PRIOR0, ~ea);
      // Capture on overflow, then read it through the override
      adder_sum = $random(seed);
      eb = adder_sum;
      overflow32_flag = 1'b1;
      @(negedge clk);
      overflow32_flag = 1'b0;
      chk(overflow32_capture, eb);
      adder_sum = ~eb;
      cpu.wr(ADDR_MAC_CTRL1, 8'h10);
      rd_word(ADDR_RESULT0, eb);
      cpu.wr(ADDR_MAC_CTRL1, 8'h00);
      cpu.wr(ADDR_RESULT1, 8'hFF);
      rd_word(ADDR_RESULT0, ~eb);
      for (i = 0; i < 8; i++) begin
         cpu.wr(ADDR_MAC_CTRL1, 8'(i % 4));
         {operand_a, operand_b} = $random(seed);
         operand_bb = 16'($random(seed));
         w = ~ea;
         sel_b = (i % 4 == 0) ? operand_b : (i % 4 == 1) ? operand_a
               : (i % 4 == 2) ? w[15:0] : operand_bb;
         repeat (2) @(negedge clk);
         eb = $signed(operand_a) * $signed(sel_b);
         chk(product, eb);
      end
      // Manual bit under method 0 must not load; bit 7 never reads back
      cpu.wr(ADDR_MAC_CTRL1, 8'hAC);
      chk(32'({ovf_hold_mode, adder_source_select}), 32'h7);
      cpu.rd(ADDR_MAC_CTRL1, d, h);
      chk(32'({h, d}), 32'h12C);
      rd_word(ADDR_PRIOR0, ~ea);
      give_verdict();
   end
endmodule : testbench

// ---- hdl/mrps_core.sv ----
// Result, prior-result and overflow capture registers with register port
`timescale 1ns/100ps

// Function
// RULE1 - Result readable as four bytes, top first; the code puts the low byte at ADDR_RESULT0, the lowest address
// RULE2 - Prior register keeps result for reuse
// RULE3 - Method 0: load prior on A-low write
// RULE4 - Method 1: load prior on manual bit
// RULE5 - Prior register 32 bits, four bytes
// RULE6 - Barrel shifter on adder, one cycle
// RULE7 - Shift reach zero to sixteen each way
// RULE8 - Shifted value feeds result, prior, capture
// RULE9 - Control bit 7 picks logical or arithmetic
// RULE10 - Bit 6 sets arithmetic left style
// RULE11 - Bits 5:0 signed amount, negative goes right
// RULE12 - Logical left shift drops sign bit
// RULE13 - Result ready for following instruction
// RULE14 - Overflow stores low 32 result bits
// RULE15 - Multiply select picks operand pair
// RULE16 - Override bit swaps capture into result
// RULE17 - Right shift fills sign or zeros
module mrps_core
   import mrps_pkg::*;
#(
   parameter int MAX_SHIFT = MAX_SHF
) (
   input  wire logic              clk,          // System clock
   input  wire logic              rstn,         // Async reset, low
   input  wire logic [7:0]        sfr_addr,     // Register address
   input  wire logic              sfr_wr,       // Write strobe
   input  wire logic [7:0]        sfr_wdata,    // Write data
   input  wire logic              sfr_rd,       // Read strobe
   output logic      [7:0]        sfr_rdata,    // Read data
   output logic                   sfr_rd_hit,   // Read was ours
   input  wire logic [OPND_W-1:0] operand_a,    // Operand A
   input  wire logic [OPND_W-1:0] operand_b,    // Operand B
   input  wire logic [OPND_W-1:0] operand_bb,   // Alternate B
   input  wire logic [RES_W-1:0]  adder_sum,    // Adder output
   input  wire logic              overflow32_flag, // 32-bit overflow
   output logic [2*OPND_W-1:0]    product,      // Registered product
   output logic [RES_W-1:0]       prior_result, // Prior result
   output logic [RES_W-1:0]       accum_result, // Live result
   output logic [RES_W-1:0]       overflow32_capture, // Captured
   output logic [1:0]             adder_source_select, // Adder source
   output logic                   ovf_hold_mode // Overflow hold mode
);

   if (MAX_SHIFT < 0) begin : g_chk
      $error("mrps_core: shift reach must not be negative");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]          ctrl1;
      logic [7:0]          shctrl;
      logic [RES_W-1:0]    result;
      logic [RES_W-1:0]    prior;
      logic [RES_W-1:0]    capture;
      logic                ovf_q;
      logic [2*OPND_W-1:0] product;
      logic [7:0]          rdata;
      logic                rd_hit;
   } mrps_state_s;

   localparam mrps_state_s STATE_RST = '{
      ctrl1:   CTL1_RST,
      shctrl:  SHC_RST,
      result:  WORD_RST,
      prior:   WORD_RST,
      capture: WORD_RST,
      ovf_q:   1'b0,
      product: WORD_RST,
      rdata:   UNMAPPED_RD,
      rd_hit:  1'b0
   };

   mrps_state_s st_r;
   mrps_state_s st_nxt;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] word_byte(input logic [RES_W-1:0] w,
                                            input logic [1:0] idx);
      word_byte = w[idx*8 +: 8];
   endfunction : word_byte

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   logic [RES_W-1:0]    shifted;
   logic [2*OPND_W-1:0] prod_now;

   mrps_shift #(
      .W         (RES_W),
      .AMT_W     (SHC_AMT_W),
      .MAX_SHIFT (MAX_SHIFT)
   ) u_shift (
      .data_in        (adder_sum),                               // RULE6
      .shift_arith    (st_r.shctrl[SHC_TYPE_BIT]),               // RULE9
      .left_keep_sign (st_r.shctrl[SHC_STYLE_BIT]),              // RULE10
      .shift_amount   (st_r.shctrl[SHC_AMT_W-1:0]),              // RULE11
      .data_out       (shifted)
   );

   mrps_mul #(
      .OW (OPND_W)
   ) u_mul (
      .op_a      (operand_a),
      .op_b      (operand_b),
      .op_alt_b  (operand_bb),
      .prior_low (st_r.prior[OPND_W-1:0]),
      .mul_sel   (st_r.ctrl1[CTL1_MULSEL_LSB +: 2]),             // RULE15
      .product   (prod_now)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic             wr_ctrl1;
   logic             wr_shc;
   logic             wr_opa_low;
   logic             manual_ld;
   logic             auto_ld;
   logic             ovf_rise;
   logic [RES_W-1:0] res_view;

   always_comb begin
      st_nxt     = st_r;
      wr_ctrl1   = sfr_wr && (sfr_addr == ADDR_MAC_CTRL1);
      wr_shc     = sfr_wr && (sfr_addr == ADDR_SHIFTER_CTL);
      wr_opa_low = sfr_wr && (sfr_addr == ADDR_OPA_LOW);

      // Manual load only counts under method 1, judged on the new value
      manual_ld  = wr_ctrl1 && sfr_wdata[CTL1_MANUAL_LOAD]
                   && sfr_wdata[CTL1_LOAD_METHOD];               // RULE4
      auto_ld    = wr_opa_low && !st_r.ctrl1[CTL1_LOAD_METHOD];  // RULE3
      ovf_rise   = overflow32_flag && !st_r.ovf_q;

      if (wr_ctrl1) begin
         // Manual load bit is a strobe and is never kept
         st_nxt.ctrl1 = sfr_wdata & CTL1_READ_MASK;
      end
      if (wr_shc) begin
         st_nxt.shctrl = sfr_wdata;
      end

      // Result tracks the shifter every cycle, so it is fresh by the
      // time the next instruction can read it
      st_nxt.result  = shifted;                                  // RULE8
      st_nxt.product = prod_now;                                 // RULE13

      // Prior takes the result standing before the new A-low lands
      if (auto_ld || manual_ld) begin
         st_nxt.prior = st_r.result;                             // RULE2
      end

      st_nxt.ovf_q = overflow32_flag;
      if (ovf_rise) begin
         st_nxt.capture = shifted;                               // RULE14
      end

      res_view = st_r.ctrl1[CTL1_OVRD_SEL] ? st_r.capture
                                           : st_r.result;        // RULE16

      if (sfr_rd) begin
         st_nxt.rd_hit = 1'b1;
         unique case (sfr_addr)
            ADDR_RESULT0:     st_nxt.rdata = word_byte(res_view, 2'h0);
            ADDR_RESULT1:     st_nxt.rdata = word_byte(res_view, 2'h1);
            ADDR_RESULT2:     st_nxt.rdata = word_byte(res_view, 2'h2);
            ADDR_RESULT3:     st_nxt.rdata = word_byte(res_view, 2'h3);
            ADDR_PRIOR0:      st_nxt.rdata = word_byte(st_r.prior, 2'h0);
            ADDR_PRIOR1:      st_nxt.rdata = word_byte(st_r.prior, 2'h1);
            ADDR_PRIOR2:      st_nxt.rdata = word_byte(st_r.prior, 2'h2);
            ADDR_PRIOR3:      st_nxt.rdata = word_byte(st_r.prior, 2'h3);
            ADDR_SHIFTER_CTL: st_nxt.rdata = st_r.shctrl;
            ADDR_MAC_CTRL1:   st_nxt.rdata = st_r.ctrl1;
            default: begin
               st_nxt.rdata  = UNMAPPED_RD;
               st_nxt.rd_hit = 1'b0;
            end
         endcase                                                 // RULE1
      end else begin
         st_nxt.rd_hit = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from flops
   // ---------------------------------------------------------------
   assign sfr_rdata           = st_r.rdata;
   assign sfr_rd_hit          = st_r.rd_hit;
   assign product             = st_r.product;
   assign prior_result        = st_r.prior;                      // RULE5
   assign accum_result        = st_r.result;
   assign overflow32_capture  = st_r.capture;
   assign adder_source_select = st_r.ctrl1[CTL1_ADDER_SOURCE_SELECT_LSB +: 2];
   assign ovf_hold_mode       = st_r.ctrl1[CTL1_OV_HOLD];

endmodule : mrps_core

// ---- hdl/mrps_mul.sv ----
// Operand selection and signed 16 by 16 multiply
`timescale 1ns/100ps

module mrps_mul
   import mrps_pkg::*;
#(
   parameter int OW = OPND_W
) (
   input  wire logic [OW-1:0]   op_a,       // Operand A
   input  wire logic [OW-1:0]   op_b,       // Operand B
   input  wire logic [OW-1:0]   op_alt_b,   // Alternate operand B
   input  wire logic [OW-1:0]   prior_low,  // Prior result low half
   input  wire logic [1:0]      mul_sel,    // Multiply select code
   output logic      [2*OW-1:0] product     // Signed product
);

   if (OW < 2) begin : g_chk
      $error("mrps_mul: operand width too small");
   end

   logic [OW-1:0] rhs;

   always_comb begin
      unique case (mrps_mul_e'(mul_sel))                         // RULE15
         MUL_A_B:     rhs = op_b;
         MUL_A_A:     rhs = op_a;
         MUL_A_PRIOR: rhs = prior_low;
         MUL_A_ALTB:  rhs = op_alt_b;
      endcase
      // Widen both sides first so the product never depends on context
      product = $signed({{OW{op_a[OW-1]}}, op_a})
                * $signed({{OW{rhs[OW-1]}}, rhs});
   end

endmodule : mrps_mul

// ---- hdl/mrps_pkg.sv ----
// Register map, field layout and codes of the result and shifter block
package mrps_pkg;

   // ---------------------------------------------------------------
   // Register addresses on the byte-wide register port
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_MAC_CTRL1   = 8'hEB;
   localparam logic [7:0] ADDR_OPA_LOW     = 8'hF2;
   localparam logic [7:0] ADDR_RESULT0     = 8'hF4;
   localparam logic [7:0] ADDR_RESULT1     = 8'hF5;
   localparam logic [7:0] ADDR_RESULT2     = 8'hF6;
   localparam logic [7:0] ADDR_RESULT3     = 8'hF7;
   localparam logic [7:0] ADDR_SHIFTER_CTL = 8'hFB;
   localparam logic [7:0] ADDR_PRIOR0      = 8'hFC;
   localparam logic [7:0] ADDR_PRIOR1      = 8'hFD;
   localparam logic [7:0] ADDR_PRIOR2      = 8'hFE;
   localparam logic [7:0] ADDR_PRIOR3      = 8'hFF;

   // ---------------------------------------------------------------
   // Control register 1 fields
   // ---------------------------------------------------------------
   localparam int CTL1_MANUAL_LOAD = 7;
   localparam int CTL1_LOAD_METHOD = 6;
   localparam int CTL1_OV_HOLD     = 5;
   localparam int CTL1_OVRD_SEL    = 4;
   localparam int CTL1_ADDER_SOURCE_SELECT_LSB  = 2;
   localparam int CTL1_MULSEL_LSB  = 0;
   localparam logic [7:0] CTL1_READ_MASK = 8'h7F;

   // ---------------------------------------------------------------
   // Shifter control fields
   // ---------------------------------------------------------------
   localparam int SHC_TYPE_BIT  = 7;
   localparam int SHC_STYLE_BIT = 6;
   localparam int SHC_AMT_W     = 6;

   // ---------------------------------------------------------------
   // Reset values and widths
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTL1_RST   = 8'h00;
   localparam logic [7:0]  SHC_RST    = 8'h00;
   localparam logic [31:0] WORD_RST   = 32'h0000_0000;
   localparam logic [7:0]  UNMAPPED_RD = 8'h00;
   localparam int RES_W   = 32;
   localparam int OPND_W  = 16;
   localparam int MAX_SHF = 16;

   typedef enum logic [1:0] {
      MUL_A_B     = 2'h0,
      MUL_A_A     = 2'h1,
      MUL_A_PRIOR = 2'h2,
      MUL_A_ALTB  = 2'h3
   } mrps_mul_e;

endpackage : mrps_pkg

// ---- hdl/mrps_shift.sv ----
// Single-cycle signed-amount barrel shifter on the adder output
`timescale 1ns/100ps

module mrps_shift
   import mrps_pkg::*;
#(
   parameter int W         = RES_W,
   parameter int AMT_W     = SHC_AMT_W,
   parameter int MAX_SHIFT = MAX_SHF
) (
   input  wire logic [W-1:0]     data_in,        // Adder output
   input  wire logic             shift_arith,    // 1 = arithmetic
   input  wire logic             left_keep_sign, // Arith left style
   input  wire logic [AMT_W-1:0] shift_amount,   // Two's complement
   output logic      [W-1:0]     data_out        // Scaled value
);

   if (MAX_SHIFT >= W || MAX_SHIFT >= (1 << (AMT_W - 1))) begin : g_chk
      $error("mrps_shift: shift range not servable");
   end

   logic             go_right;
   logic [AMT_W-1:0] mag_raw;
   logic [AMT_W-1:0] mag;
   logic [W-1:0]     left_val;

   always_comb begin
      go_right = shift_amount[AMT_W-1];                          // RULE11
      mag_raw  = go_right ? AMT_W'(~shift_amount + 1'b1) : shift_amount;
      // Out-of-range amounts saturate at the documented reach
      mag      = (mag_raw > AMT_W'(MAX_SHIFT)) ? AMT_W'(MAX_SHIFT)
                                               : mag_raw;        // RULE7
      left_val = data_in << mag;                                 // RULE12
      if (go_right) begin
         if (shift_arith) begin
            data_out = W'($signed(data_in) >>> mag);             // RULE17
         end else begin
            data_out = data_in >> mag;                           // RULE17
         end
      end else if (shift_arith && left_keep_sign) begin
         data_out = {data_in[W-1], left_val[W-2:0]};             // RULE10
      end else begin
         data_out = left_val;                                    // RULE12
      end
   end

endmodule : mrps_shift
